// ===== core/lcd_defines.svh
// Register map, field positions, reset values and counts for the LED channel dimming block
`ifndef LCD_DEFINES_SVH
`define LCD_DEFINES_SVH

// ==========================================================
// Register map
`define LCD_ADDR_SYNC       12'h000
`define LCD_ADDR_GLOBAL     12'h004
`define LCD_CH_BASE_IDX     4'h1
`define LCD_OFS_DUTY        2'h0
`define LCD_OFS_MODE        2'h1
`define LCD_OFS_STATUS      2'h2

// ==========================================================
// Field positions and widths
`define LCD_DUTY_W          13
`define LCD_SCALE_BASE      6
`define LCD_MODE_W          9
`define LCD_STAT_SHORT      0
`define LCD_STAT_OV         1
`define LCD_STAT_OPEN       2
`define LCD_STAT_W1C_W      3
`define LCD_STAT_GEN        3
`define LCD_STAT_GATE       4
`define LCD_STAT_RUN        5
`define LCD_GLB_STANDALONE  0
`define LCD_GLB_ALERT       1

// ==========================================================
// Reset values and counts
`define LCD_DUTY_RST        13'h0000
`define LCD_MODE_RST        9'h001
`define LCD_HICCUP_CYCLES   7168
`define LCD_NUM_CH          4

`endif

// ===== core/lcd_dim_gen.sv
// Variable length dimming counter with pulse-width and bit-angle compare
`timescale 1ns/100ps
`include "lcd_defines.svh"
module lcd_dim_gen #(
    parameter int DW = `LCD_DUTY_W
) (
    input  wire logic          sys_clk,
    input  wire logic          resetn,
    input  wire logic          ce,
    input  wire logic          gen_enable,
    input  wire logic          ext_dim,
    input  wire logic          restart,
    input  wire logic [DW-1:0] duty_code,
    input  wire logic          bit_angle_select,
    input  wire logic [2:0]    scale,
    output logic               light_gen_out
);

    logic [DW-1:0] cnt_ff;
    logic [DW-1:0] active_ff;
    logic          en_prev_ff;
    logic [DW-1:0] mask;
    logic [DW-1:0] duty_m;
    logic          cmp_pwm;
    logic          cmp_bam;
    logic          load;

    // ==========================================================
    // Compare
    assign mask   = DW'((32'h1 << (`LCD_SCALE_BASE + 32'(scale))) - 32'h1);
    assign duty_m = active_ff & mask;
    assign cmp_pwm = duty_m > cnt_ff;

    always_comb begin
        cmp_bam = 1'b0;
        for (int i = 0; i < DW; i++) begin
            if (cnt_ff[i]) begin
                cmp_bam = duty_m[i];
            end
        end
    end

    // Counter zero has no set bit, so bit-angle output stays low there
    assign load = restart || (gen_enable && !en_prev_ff);

    // ==========================================================
    // Counter
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_ff     <= '0;
            active_ff  <= `LCD_DUTY_RST;
            en_prev_ff <= 1'b0;
        end else if (ce) begin
            en_prev_ff <= gen_enable;
            if (!gen_enable || !ext_dim) begin
                cnt_ff    <= '0;
                active_ff <= duty_code;
            end else if (load) begin
                cnt_ff    <= '0;
                active_ff <= duty_code;
            end else if (cnt_ff == mask) begin
                cnt_ff    <= '0;
                active_ff <= duty_code;
            end else begin
                cnt_ff <= cnt_ff + 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            light_gen_out <= 1'b0;
        end else if (ce) begin
            if (load || !gen_enable || !ext_dim) begin
                light_gen_out <= 1'b0;
            end else begin
                light_gen_out <= bit_angle_select ? cmp_bam : cmp_pwm;
            end
        end
    end

endmodule // lcd_dim_gen

// ===== core/lcd_fault.sv
// Per channel short, overvoltage and open flags, with hiccup or latch-off response to a short only
`timescale 1ns/100ps
`include "lcd_defines.svh"
module lcd_fault #(
    parameter int HICCUP_CYCLES = `LCD_HICCUP_CYCLES
) (
    input  wire logic                 sys_clk,
    input  wire logic                 resetn,
    input  wire logic                 ce,
    input  wire logic                 short_det,
    input  wire logic                 ov_det,
    input  wire logic                 open_det,
    input  wire logic                 softstart_done,
    input  wire logic                 fault_latch_select,
    input  wire lcd_pkg::lcd_flags_t  flag_clr,
    output lcd_pkg::lcd_flags_t       flags_ff,
    output logic                      run_ok,
    output logic                      softstart_restart_ff
);

    localparam int CW = $clog2(HICCUP_CYCLES + 1);

    lcd_pkg::lcd_fault_st_t st_ff;
    logic [CW-1:0]          cool_ff;
    logic                   short_hit;

    assign short_hit = (st_ff == lcd_pkg::LCD_RUN) && softstart_done && short_det;
    assign run_ok    = (st_ff == lcd_pkg::LCD_RUN);

    // ==========================================================
    // Sticky flags: a new event beats a clear in the same cycle
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            flags_ff <= '0;
        end else if (ce) begin
            flags_ff.short_out <= short_hit
                || (flags_ff.short_out && !flag_clr.short_out);
            flags_ff.feedback_overvoltage_flag <= ov_det
                || (flags_ff.feedback_overvoltage_flag
                    && !flag_clr.feedback_overvoltage_flag);
            flags_ff.open_out <= open_det
                || (flags_ff.open_out && !flag_clr.open_out);
        end
    end

    // ==========================================================
    // Response state
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            st_ff                <= lcd_pkg::LCD_RUN;
            cool_ff              <= '0;
            softstart_restart_ff <= 1'b0;
        end else if (ce) begin
            softstart_restart_ff <= 1'b0;
            unique case (st_ff)
                lcd_pkg::LCD_RUN: begin
                    if (short_hit) begin
                        cool_ff <= CW'(HICCUP_CYCLES - 1);
                        st_ff   <= fault_latch_select ? lcd_pkg::LCD_LATCHED
                                                      : lcd_pkg::LCD_COOL;
                    end
                end
                lcd_pkg::LCD_COOL: begin
                    if (cool_ff == '0) begin
                        st_ff                <= lcd_pkg::LCD_RUN;
                        softstart_restart_ff <= 1'b1;
                    end else begin
                        cool_ff <= cool_ff - 1'b1;
                    end
                end
                lcd_pkg::LCD_LATCHED: begin
                    if (!flags_ff.short_out || !fault_latch_select) begin
                        st_ff                <= lcd_pkg::LCD_RUN;
                        softstart_restart_ff <= 1'b1;
                    end
                end
                default: st_ff <= lcd_pkg::LCD_RUN;
            endcase
        end
    end

endmodule // lcd_fault

// ===== core/lcd_pkg.sv
// Types shared by the LED channel dimming block
package lcd_pkg;

    // ==========================================================
    // Channel mode register
    typedef struct packed {
        logic       open_report_enable;
        logic       overvoltage_report_enable;
        logic       short_report_enable;
        logic       fault_latch_select;
        logic [2:0] scale;
        logic       bit_angle_select;
        logic       light_gen_enable;
    } lcd_mode_t;

    // ==========================================================
    // Sticky fault flags
    typedef struct packed {
        logic open_out;
        logic feedback_overvoltage_flag;
        logic short_out;
    } lcd_flags_t;

    // ==========================================================
    // Fault response state
    typedef enum logic [1:0] {
        LCD_RUN,
        LCD_COOL,
        LCD_LATCHED
    } lcd_fault_st_t;

endpackage

// ===== core/lcd_top.sv
// LED channel dimming generators, fault flags and APB register file
//
// Local design decisions: the register addresses and the APB register port.
`timescale 1ns/100ps
`include "lcd_defines.svh"
module lcd_top #(
    parameter int NCH           = `LCD_NUM_CH,
    parameter int HICCUP_CYCLES = `LCD_HICCUP_CYCLES
) (
    input  wire logic           sys_clk,
    input  wire logic           resetn,
    input  wire logic           ce,
    // APB slave
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [11:0]    paddr,
    input  wire logic [31:0]    pwdata,
    output logic                pready,
    output logic [31:0]         prdata,
    output logic                pslverr,
    // Pins and comparators, all asynchronous to sys_clk
    input  wire logic           standalone_strap,
    input  wire logic [NCH-1:0] ext_dim,
    input  wire logic [NCH-1:0] fb_short_cmp,
    input  wire logic [NCH-1:0] feedback_overvoltage_cmp,
    input  wire logic [NCH-1:0] fb_open_cmp,
    input  wire logic [NCH-1:0] softstart_done,
    // Power stage controls
    output logic [NCH-1:0]      switch_enable,
    output logic [NCH-1:0]      output_disconnect_gate,
    output logic [NCH-1:0]      control_hold,
    output logic [NCH-1:0]      softstart_restart,
    output logic [NCH-1:0]      light_gen_out,
    output logic                alert
);

    localparam int NS = 5 * NCH + 1;

    // ==========================================================
    // Input synchronisers
    logic [NS-1:0] sync1_ff;
    logic [NS-1:0] sync2_ff;
    logic [NCH-1:0] ext_dim_s;
    logic [NCH-1:0] short_s;
    logic [NCH-1:0] ov_s;
    logic [NCH-1:0] open_s;
    logic [NCH-1:0] ss_done_s;
    logic           standalone_s;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else if (ce) begin
            sync1_ff <= {standalone_strap, softstart_done, fb_open_cmp,
                         feedback_overvoltage_cmp, fb_short_cmp, ext_dim};
            sync2_ff <= sync1_ff;
        end
    end

    assign ext_dim_s    = sync2_ff[0 +: NCH];
    assign short_s      = sync2_ff[NCH +: NCH];
    assign ov_s         = sync2_ff[2*NCH +: NCH];
    assign open_s       = sync2_ff[3*NCH +: NCH];
    assign ss_done_s    = sync2_ff[4*NCH +: NCH];
    assign standalone_s = sync2_ff[NS-1];

    // ==========================================================
    // APB decode
    logic        rd_valid_ff;
    logic        wr_en;
    logic        hit_sync;
    logic        hit_global;
    logic [3:0]  blk;
    logic [1:0]  ofs;
    logic        blk_ok;
    logic        ofs_ok;
    logic        map_ok;
    logic [31:0] rd_mux;
    logic        sync_pulse_ff;

    assign pready     = psel && penable && rd_valid_ff && ce;
    assign wr_en      = pready && pwrite && map_ok;
    assign hit_sync   = (paddr == `LCD_ADDR_SYNC);
    assign hit_global = (paddr == `LCD_ADDR_GLOBAL);
    assign blk        = paddr[7:4];
    assign ofs        = paddr[3:2];
    assign blk_ok     = (paddr[11:8] == 4'h0) && (blk >= `LCD_CH_BASE_IDX)
                        && (32'(blk) < 32'(`LCD_CH_BASE_IDX) + 32'(NCH));
    assign ofs_ok     = (ofs != 2'h3) && (paddr[1:0] == 2'h0);
    assign map_ok     = hit_sync || hit_global || (blk_ok && ofs_ok);

    // ==========================================================
    // Channel registers and logic
    logic [`LCD_DUTY_W-1:0] duty_ff [NCH];
    lcd_pkg::lcd_mode_t     mode_ff [NCH];
    lcd_pkg::lcd_flags_t    flags   [NCH];
    lcd_pkg::lcd_flags_t    clr     [NCH];
    logic [NCH-1:0]         gen_raw;
    logic [NCH-1:0]         run_ok;
    logic [NCH-1:0]         ss_pulse;
    logic [NCH-1:0]         alert_ch;
    logic [NCH-1:0]         dim_on;

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            logic sel;
            logic gen_active;
            logic latch_sel;

            assign sel = blk_ok && (32'(blk) == 32'(`LCD_CH_BASE_IDX) + 32'(g));

            always_ff @(posedge sys_clk or negedge resetn) begin
                if (!resetn) begin
                    duty_ff[g] <= `LCD_DUTY_RST;
                    mode_ff[g] <= `LCD_MODE_RST;
                end else if (ce && wr_en && sel) begin
                    if (ofs == `LCD_OFS_DUTY) begin
                        duty_ff[g] <= pwdata[`LCD_DUTY_W-1:0];
                    end
                    if (ofs == `LCD_OFS_MODE) begin
                        mode_ff[g] <= pwdata[`LCD_MODE_W-1:0];
                    end
                end
            end

            // The three sticky status flags, bits 0 to 2, clear on a written one
            assign clr[g] = (wr_en && sel && ofs == `LCD_OFS_STATUS)
                            ? pwdata[`LCD_STAT_W1C_W-1:0] : '0;

            // Standalone straps turn the generator off and never latch
            assign gen_active = mode_ff[g].light_gen_enable && !standalone_s;
            assign latch_sel  = mode_ff[g].fault_latch_select && !standalone_s;

            lcd_dim_gen #(
                .DW (`LCD_DUTY_W)
            ) u_gen (
                .sys_clk          (sys_clk),
                .resetn           (resetn),
                .ce               (ce),
                .gen_enable       (gen_active),
                .ext_dim          (ext_dim_s[g]),
                .restart          (sync_pulse_ff),
                .duty_code        (duty_ff[g]),
                .bit_angle_select (mode_ff[g].bit_angle_select),
                .scale            (mode_ff[g].scale),
                .light_gen_out    (gen_raw[g])
            );

            lcd_fault #(
                .HICCUP_CYCLES (HICCUP_CYCLES)
            ) u_fault (
                .sys_clk              (sys_clk),
                .resetn               (resetn),
                .ce                   (ce),
                .short_det            (short_s[g]),
                .ov_det               (ov_s[g]),
                .open_det             (open_s[g]),
                .softstart_done       (ss_done_s[g]),
                .fault_latch_select   (latch_sel),
                .flag_clr             (clr[g]),
                .flags_ff             (flags[g]),
                .run_ok               (run_ok[g]),
                .softstart_restart_ff (ss_pulse[g])
            );

            // Generator off leaves the external input in sole control
            assign dim_on[g] = ext_dim_s[g] && (gen_active ? gen_raw[g] : 1'b1);

            assign alert_ch[g] =
                (flags[g].short_out && mode_ff[g].short_report_enable)
                || (flags[g].feedback_overvoltage_flag
                    && mode_ff[g].overvoltage_report_enable)
                || (flags[g].open_out && mode_ff[g].open_report_enable);

            // Overvoltage uses the live comparator so switching resumes on its fall
            always_ff @(posedge sys_clk or negedge resetn) begin
                if (!resetn) begin
                    switch_enable[g]          <= 1'b0;
                    output_disconnect_gate[g] <= 1'b1;
                    control_hold[g]           <= 1'b1;
                end else if (ce) begin
                    switch_enable[g]          <= dim_on[g] && run_ok[g] && !ov_s[g];
                    output_disconnect_gate[g] <= !(dim_on[g] && run_ok[g] && !ov_s[g]);
                    control_hold[g]           <= !dim_on[g];
                end
            end
        end
    endgenerate

    assign light_gen_out     = gen_raw;
    assign softstart_restart = ss_pulse;

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            alert <= 1'b0;
        end else if (ce) begin
            alert <= |alert_ch;
        end
    end

    // ==========================================================
    // Broadcast synchronisation strobe
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sync_pulse_ff <= 1'b0;
        end else if (ce) begin
            sync_pulse_ff <= wr_en && hit_sync;
        end
    end

    // ==========================================================
    // Read data, captured from flops one cycle before the answer
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_global) begin
            rd_mux[`LCD_GLB_STANDALONE] = standalone_s;
            rd_mux[`LCD_GLB_ALERT]      = alert;
        end
        for (int c = 0; c < NCH; c++) begin
            if (blk_ok && 32'(blk) == 32'(`LCD_CH_BASE_IDX) + 32'(c)) begin
                unique case (ofs)
                    `LCD_OFS_DUTY:   rd_mux[`LCD_DUTY_W-1:0] = duty_ff[c];
                    `LCD_OFS_MODE:   rd_mux[`LCD_MODE_W-1:0] = mode_ff[c];
                    `LCD_OFS_STATUS: begin
                        rd_mux[`LCD_STAT_W1C_W-1:0] = flags[c];
                        rd_mux[`LCD_STAT_GEN]       = gen_raw[c];
                        rd_mux[`LCD_STAT_GATE]      = output_disconnect_gate[c];
                        rd_mux[`LCD_STAT_RUN]       = run_ok[c];
                    end
                    default:         rd_mux = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rd_valid_ff <= 1'b0;
            prdata      <= 32'h0000_0000;
            pslverr     <= 1'b0;
        end else if (ce) begin
            if (pready) begin
                rd_valid_ff <= 1'b0;
            end else if (psel && !rd_valid_ff) begin
                rd_valid_ff <= 1'b1;
                prdata      <= pwrite ? 32'h0000_0000 : rd_mux;
                pslverr     <= !map_ok;
            end
        end
    end

endmodule // lcd_top

// ===== testbench/lcd_stage_model.sv
// Power stage model: soft-start timer and feedback comparators
`timescale 1ns/100ps
module lcd_stage_model #(
    parameter int NCH = 4
) (
    input  wire logic           sys_clk,
    input  wire logic           resetn,
    input  wire logic [NCH-1:0] softstart_restart,
    input  wire logic [NCH-1:0] short_req,
    input  wire logic [NCH-1:0] ov_req,
    input  wire logic [NCH-1:0] open_req,
    output logic      [NCH-1:0] softstart_done,
    output logic      [NCH-1:0] fb_short_cmp,
    output logic      [NCH-1:0] feedback_overvoltage_cmp,
    output logic      [NCH-1:0] fb_open_cmp
);
    // ==========
    // Soft-start ramp, a fixed eight cycles after each restart
    logic [3:0] ss_ff [NCH];
    always_ff @(posedge sys_clk or negedge resetn) begin
        for (int i = 0; i < NCH; i++) begin
            if (!resetn || softstart_restart[i]) begin
                ss_ff[i] <= 4'h0;
            end else if (ss_ff[i] != 4'h8) begin
                ss_ff[i] <= ss_ff[i] + 4'h1;
            end
        end
    end
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            softstart_done[i] = (ss_ff[i] == 4'h8);
        end
    end
    // A shorted output pins feedback low until the short goes away
    assign fb_short_cmp = short_req;
    assign feedback_overvoltage_cmp = ov_req;
    assign fb_open_cmp = open_req;
endmodule // lcd_stage_model

// ===== testbench/lcd_top_properties.sv
// Concurrent checks on the dimming block ports
`timescale 1ns/100ps
module lcd_props #(
    parameter int NCH = 4
) (
    input wire logic           sys_clk,
    input wire logic           resetn,
    input wire logic           ce,
    input wire logic           psel,
    input wire logic           penable,
    input wire logic           pwrite,
    input wire logic [11:0]    paddr,
    input wire logic           pready,
    input wire logic [NCH-1:0] ext_dim,
    input wire logic [NCH-1:0] feedback_overvoltage_cmp,
    input wire logic [NCH-1:0] switch_enable,
    input wire logic [NCH-1:0] output_disconnect_gate,
    input wire logic [NCH-1:0] control_hold,
    input wire logic [NCH-1:0] softstart_restart,
    input wire logic [NCH-1:0] light_gen_out,
    input wire logic           alert
);
    // ==========
    // Properties
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence apb_setup; psel && !penable && ce; endsequence
    sequence apb_access; psel && penable && ce; endsequence
    sequence sync_wr; psel && penable && pready && pwrite && paddr == 12'h000; endsequence
    apb_zero_wait_a: assert property (apb_setup ##1 apb_access |-> pready)
        else $error("pready late");
    gate_sw_a: assert property (switch_enable[0] |-> !output_disconnect_gate[0])
        else $error("gate on while off");
    hold_sw_a: assert property (control_hold[0] |-> !switch_enable[0])
        else $error("switching while held");
    ov_stop_a: assert property (feedback_overvoltage_cmp[0] [*3] |-> ##[1:3] !switch_enable[0]
        && output_disconnect_gate[0]) else $error("no overvoltage stop");
    sync_low_a: assert property (sync_wr |-> ##[1:3] light_gen_out == '0)
        else $error("no restart low");
    ss_pulse_a: assert property (softstart_restart[0] |=> !softstart_restart[0])
        else $error("restart not a pulse");
    alert_hold_a: assert property ($fell(alert) |-> $past(psel && penable && pwrite)
        || $past(psel && penable && pwrite, 2)) else $error("alert dropped alone");
    ext_low_a: assert property (!ext_dim[0] [*5] |-> !switch_enable[0])
        else $error("switching with input low");
endmodule // lcd_props

bind lcd_top lcd_props #(.NCH(NCH)) u_props (.sys_clk, .resetn, .ce, .psel, .penable, .pwrite,
    .paddr, .pready, .ext_dim, .feedback_overvoltage_cmp, .switch_enable,
    .output_disconnect_gate, .control_hold, .softstart_restart, .light_gen_out, .alert);

// ===== testbench/led_channel_dimming_and_fault_logic_tb_top.sv
// Self-checking bench for the LED channel dimming block
`timescale 1ns/100ps
module led_channel_dimming_and_fault_logic_tb_top;
    localparam int NCH = 4;
    localparam int HC = 16;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic ce = 1'b1;
    logic standalone_strap = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic pready, pslverr, alert, rerr, seen;
    logic [31:0] prdata, rdat;
    logic [NCH-1:0] ext_dim = 4'hf, shrt = 4'h0, ovr = 4'h0, opn = 4'h0;
    logic [NCH-1:0] switch_enable, output_disconnect_gate, control_hold, softstart_restart;
    logic [NCH-1:0] light_gen_out, softstart_done, fb_short_cmp, feedback_overvoltage_cmp;
    logic [NCH-1:0] fb_open_cmp;
    logic [8:0] md [7] = '{9'h001, 9'h001, 9'h003, 9'h001, 9'h005, 9'h000, 9'h001};
    logic [12:0] dc [7] = '{13'h0, 13'h000d, 13'h000d, 13'h0041, 13'h0064, 13'h000d, 13'h000d};
    int ex [7] = '{0, 26, 26, 2, 200, 128, 0};
    int bad_count = 0;
    int cmp_count = 0;
    always #2.5 sys_clk = ~sys_clk;
    lcd_top #(.NCH(NCH), .HICCUP_CYCLES(HC)) DUT (.sys_clk, .resetn, .ce, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .standalone_strap, .ext_dim,
        .fb_short_cmp, .feedback_overvoltage_cmp, .fb_open_cmp, .softstart_done,
        .switch_enable, .output_disconnect_gate, .control_hold, .softstart_restart,
        .light_gen_out, .alert);
    lcd_stage_model #(.NCH(NCH)) u_stage (.sys_clk, .resetn, .softstart_restart,
        .short_req(shrt), .ov_req(ovr), .open_req(opn), .softstart_done, .fb_short_cmp,
        .feedback_overvoltage_cmp, .fb_open_cmp);
    // ==========
    // Shared tasks
    task automatic conclude;
        $display("Compares %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            chk("pready", 0, 1);
            conclude();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic pulse_in(input int lim);
        seen = 1'b0;
        repeat (lim) begin
            @(posedge sys_clk);
            seen = seen | softstart_restart[0];
        end
    endtask
    // ==========
    // Scenarios
    task automatic t_regs;
        apb(0, 12'h014, 0);
        chk("mode", rdat, 32'h1);
        apb(0, 12'h010, 0);
        chk("duty", rdat, 32'h0);
        apb(0, 12'h01c, 0);
        chk("unmapped", rerr, 1);
    endtask
    task automatic t_dim;
        int per;
        int hi;
        for (int i = 0; i < 7; i++) begin
            ext_dim[0] <= (i != 6);
            apb(1, 12'h014, {23'h0, md[i]});
            apb(1, 12'h010, {19'h0, dc[i]});
            per = 64 << md[i][4:2];
            hi = 0;
            repeat (3 * per) @(posedge sys_clk);
            repeat (2 * per) begin
                @(posedge sys_clk);
                hi += switch_enable[0];
            end
            chk("dim high", hi, ex[i]);
        end
    endtask
    task automatic t_sync;
        int hi;
        hi = 0;
        ext_dim[0] <= 1'b1;
        apb(1, 12'h000, 0);
        repeat (30) @(posedge sys_clk);
        apb(1, 12'h010, 32'h32);
        repeat (20) begin
            @(posedge sys_clk);
            hi += switch_enable[0];
        end
        chk("old duty kept", hi, 0);
        hi = 0;
        repeat (64) @(posedge sys_clk);
        repeat (128) begin
            @(posedge sys_clk);
            hi += switch_enable[0];
        end
        chk("new duty", hi, 100);
    endtask
    task automatic t_short;
        apb(1, 12'h014, 32'h040);
        shrt[0] <= 1'b1;
        pulse_in(HC - 2);
        chk("early retry", seen, 0);
        pulse_in(60);
        chk("hiccup retry", seen, 1);
        apb(0, 12'h018, 0);
        chk("short flag", rdat[2:0], 3'h1);
        chk("alert", alert, 1);
        apb(1, 12'h014, 32'h060);
        shrt[0] <= 1'b0;
        apb(1, 12'h018, 32'h7);
        shrt[0] <= 1'b1;
        pulse_in(20);
        apb(0, 12'h018, 0);
        chk("short again", rdat[0], 1);
        pulse_in(60);
        chk("latched", seen, 0);
        shrt[0] <= 1'b0;
        apb(1, 12'h018, 32'h7);
        pulse_in(20);
        chk("release", seen, 1);
        chk("alert off", alert, 0);
    endtask
    task automatic t_flag(input logic [31:0] m, input int b, input logic swx);
        apb(1, 12'h014, m);
        if (b == 1) ovr[0] <= 1'b1;
        else opn[0] <= 1'b1;
        repeat (12) @(posedge sys_clk);
        chk("switch", switch_enable[0], swx);
        chk("gate", output_disconnect_gate[0], !swx);
        chk("alert", alert, 1);
        ovr[0] <= 1'b0;
        opn[0] <= 1'b0;
        repeat (12) @(posedge sys_clk);
        chk("resume", switch_enable[0], 1);
        apb(0, 12'h018, 0);
        chk("flag", rdat[2:0], 32'h1 << b);
        apb(1, 12'h018, 32'h7);
    endtask
    initial begin
        repeat (16) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        t_regs();
        t_dim();
        t_sync();
        t_short();
        t_flag(32'h080, 1, 1'b0);
        t_flag(32'h100, 2, 1'b1);
        conclude();
    end
endmodule // led_channel_dimming_and_fault_logic_tb_top
